// file: include/trap_seq_pkg.sv
// Purpose: constants and carriers of the trap and interrupt sequencer
// Assumes: one instruction cycle per clock, APB register access
// Notes:   all offsets are byte addresses of 32-bit words
// Summary of operation
// [RULE_01] Any reset restarts fetch at address zero
// [RULE_02] Word zero holds jump to start address
// [RULE_03] Watchdog, uninit pointer, bad opcode, lockout reset
// [RULE_04] Flushed unused opcode raises no trap
// [RULE_05] Traps unmaskable, levels 8-15, trap bit set
// [RULE_06] Level 0111 blocks interrupts, not traps
// [RULE_07] Offending instruction completes before trap entry
// [RULE_08] Divide by zero, oversize shift take math trap
// [RULE_09] Enabled accumulator overflows take math trap
// [RULE_10] Misaligned, unimplemented, vector fetch: address trap
// [RULE_11] Cross X/Y path access counts unimplemented
// [RULE_12] Jumps into unimplemented program raise address trap
// [RULE_13] Stack pointer above limit or below floor
// [RULE_14] Oscillator failure raises its trap
// [RULE_15] Fixed trap ranks: math 11, hard 12-14
// [RULE_16] Lower hard trap during higher: reset, flag
// [RULE_17] Flags sampled every cycle, enabled flag requests
// [RULE_18] Interrupt only when strictly above current level
// [RULE_19] Push PC and status, load level, pop back
// [RULE_20] Trap bit clear for interrupts, set for traps
// [RULE_21] Alternate table select moves every vector fetch
// [RULE_22] Default vectors 0x04-0xFE; fetching them traps
// [RULE_23] Alternate select is bit 15 of control two
// [RULE_24] Trap beats interrupt in the same cycle
package trap_seq_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0]  REG_CTRL1   = 8'h00;
   localparam logic [7:0]  REG_CTRL2   = 8'h04;
   localparam logic [7:0]  REG_FLAG    = 8'h08;
   localparam logic [7:0]  REG_ENABLE  = 8'h0C;
   localparam logic [7:0]  REG_STACK_LIMIT_REG   = 8'h10;
   localparam logic [7:0]  REG_SR      = 8'h14;
   localparam logic [7:0]  REG_CORE    = 8'h18;
   localparam logic [7:0]  REG_RESET   = 8'h1C;
   localparam logic [7:0]  REG_STATE   = 8'h20;

   // ****************************************
   // Field positions and reset values
   // ****************************************
   localparam int          B_OVF_EN    = 10;
   localparam int          B_CAT_EN    = 8;
   localparam int          B_SHIFT     = 7;
   localparam int          B_DIV0      = 6;
   localparam int          B_MATH      = 4;
   localparam int          B_ADDR      = 3;
   localparam int          B_STK       = 2;
   localparam int          B_OSC       = 1;
   localparam int          B_ALT       = 15;
   localparam int          B_TRAP_BIT  = 3;
   localparam int          B_CONFLICT  = 15;
   localparam int          B_ILLEGAL   = 14;
   localparam int          B_WDT       = 4;
   localparam int          B_UNINIT    = 1;
   localparam int          SR_IPL_LSB  = 5;
   localparam logic [15:0] CTRL1_WMASK = 16'h05DE;
   localparam logic [15:0] CTRL1_RST   = 16'h0000;
   localparam logic [15:0] STACK_LIMIT_REG_RST   = 16'h0FFE;
   localparam logic [15:0] SP_FLOOR    = 16'h0800;

   // ****************************************
   // Program space and levels
   // ****************************************
   localparam logic [23:0] RESET_VEC   = 24'h000000;
   localparam logic [23:0] DEF_LO      = 24'h000004;
   localparam logic [23:0] DEF_HI      = 24'h0000FE;
   localparam logic [23:0] ALT_LO      = 24'h000104;
   localparam logic [23:0] ALT_HI      = 24'h0001FE;
   localparam logic [23:0] PROG_END    = 24'h002000;
   localparam logic [3:0]  LVL_MATH    = 4'hB;
   localparam logic [3:0]  LVL_HARD0   = 4'hC;
   localparam logic [3:0]  LVL_TRAP0   = 4'h8;
   localparam logic [5:0]  IRQ_VEC0    = 6'h08;
   localparam int          N_IRQ       = 16;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic        instr_done;
      logic        div_zero;
      logic        shift_over;
      logic        acc_ovf31;
      logic        guard_used;
      logic        acc_ovf39;
      logic        sat_en;
      logic        misaligned;
      logic        unimpl_data;
      logic        unimpl_prog;
      logic        mac_split;
      logic        x_into_y;
      logic        y_into_x;
      logic        branch_bad;
      logic        fetch_valid;
      logic [23:0] fetch_addr;
      logic        illegal_op;
      logic        flushed;
      logic        uninit_w;
      logic        wdt_timeout;
      logic        sp_load;
      logic [15:0] sp_value;
      logic        osc_fail;
      logic        ret_op;
      logic [23:0] pc;
   } core_evt_t;

   typedef struct packed {
      logic [23:0] pc;
      logic [7:0]  status_low_byte;
      logic        trap_bit;
   } frame_t;

endpackage

// file: verilog/trap_rank.sv
// Purpose: rank pending traps and detect hard trap conflicts
// Assumes: bit i of a hard vector is level 12+i
// Notes:   purely combinational
`timescale 1ns/1ns
module trap_rank
   import trap_seq_pkg::*;
(
   // Trap state
   input  wire logic       i_soft_pend,
   input  wire logic [3:0] i_hard_pend,
   input  wire logic [3:0] i_hard_srv,
   input  wire logic [3:0] i_hard_new,
   // Result
   output logic            o_any,
   output logic [3:0]      o_level,
   output logic [3:0]      o_top_hard,
   output logic            o_conflict
);
   logic [3:0] busy;
   assign busy = i_hard_pend | i_hard_srv | i_hard_new;

   always_comb begin
      o_any      = i_soft_pend | (|i_hard_pend);
      o_level    = i_soft_pend ? LVL_MATH : 4'h0; // see [RULE_15]
      o_top_hard = 4'h0;
      o_conflict = 1'b0;
      for (int i = 0; i < 4; i++) begin
         if (i_hard_pend[i]) begin
            o_level    = LVL_HARD0 + 4'(i);
            o_top_hard = 4'(1 << i);
         end
         for (int j = i + 1; j < 4; j++) begin
            if (i_hard_new[i] && busy[j]) begin
               o_conflict = 1'b1; // see [RULE_16]
            end
         end
      end
   end
endmodule

// file: verilog/irq_pick.sv
// Purpose: pick the highest priority pending enabled request
// Assumes: priority 0 means the source is disabled
// Notes:   ties go to the lowest source index
`timescale 1ns/1ns
module irq_pick
   import trap_seq_pkg::*;
(
   // Requests
   input  wire logic [N_IRQ-1:0]      i_req,
   input  wire logic [N_IRQ-1:0][2:0] i_prio,
   // Winner
   output logic [2:0]                 o_level,
   output logic [3:0]                 o_index
);
   always_comb begin
      o_level = 3'h0;
      o_index = 4'h0;
      for (int i = N_IRQ - 1; i >= 0; i--) begin
         if (i_req[i] && i_prio[i] >= o_level && i_prio[i] != 3'h0) begin
            o_level = i_prio[i];
            o_index = 4'(i);
         end
      end
   end
endmodule

// file: verilog/trap_and_interrupt_sequencer.sv
// Purpose: trap detection, ranking, interrupt selection, reset causes
// Assumes: one clock is one instruction cycle; the core pushes frames
// Notes:   registers reached over APB with no wait states
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ns
module trap_and_interrupt_sequencer
   import trap_seq_pkg::*;
(
   // Clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_resetn,
   // APB slave
   input  wire logic                  i_psel,
   input  wire logic                  i_penable,
   input  wire logic                  i_pwrite,
   input  wire logic [7:0]            i_paddr,
   input  wire logic [31:0]           i_pwdata,
   output logic [31:0]                o_prdata,
   output logic                       o_pready,
   output logic                       o_pslverr,
   // Core pipeline
   input  wire core_evt_t             i_evt,
   input  wire frame_t                i_pop,
   output logic                       o_core_reset,
   output logic                       o_pc_load,
   output logic [23:0]                o_pc_value,
   output logic                       o_take,
   output logic [23:0]                o_vector,
   output frame_t                     o_frame,
   output logic [3:0]                 o_level,
   // Peripherals
   input  wire logic [N_IRQ-1:0]      i_irq_evt,
   input  wire logic [N_IRQ-1:0][2:0] i_irq_prio
);

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic in_range(input logic [23:0] a,
                                     input logic [23:0] lo,
                                     input logic [23:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   function automatic logic is_wr(input logic [7:0] a,
                                  input logic       go,
                                  input logic [7:0] sel);
      is_wr = go && (a == sel);
   endfunction

   // ****************************************
   // State
   // ****************************************
   logic [15:0]      ctrl1_r;
   logic             alt_r;
   logic [N_IRQ-1:0] flag_r;
   logic [N_IRQ-1:0] enable_r;
   logic [15:0]      stack_limit_reg_r;
   logic [2:0]       ipl_r;
   logic             trap_bit_r;
   logic [15:0]      reset_control_reg_r;
   logic             math_pend_r;
   logic [3:0]       hard_pend_r;
   logic [3:0]       hard_srv_r;
   logic             osc_prev_r;
   logic             pready_r;
   logic             pslverr_r;
   logic [31:0]      prdata_r;
   logic             core_reset_r;
   logic             pc_load_r;
   logic [23:0]      pc_value_r;
   logic             take_r;
   logic [23:0]      vector_r;
   frame_t           frame_r;

   // ****************************************
   // Bus decode
   // ****************************************
   logic        setup;
   logic        wr_go;
   logic        hit;
   logic [31:0] rd_mux;
   logic [31:0] state_word;

   assign setup = i_psel & ~i_penable;
   assign wr_go = i_psel & i_penable & i_pwrite & pready_r;
   assign hit   = (i_paddr == REG_CTRL1) | (i_paddr == REG_CTRL2)
                | (i_paddr == REG_FLAG) | (i_paddr == REG_ENABLE)
                | (i_paddr == REG_STACK_LIMIT_REG) | (i_paddr == REG_SR)
                | (i_paddr == REG_CORE) | (i_paddr == REG_RESET)
                | (i_paddr == REG_STATE);
   assign state_word = {16'h0000, hard_srv_r, hard_pend_r,
                        3'h0, math_pend_r, trap_bit_r, ipl_r};
   assign rd_mux =
      (i_paddr == REG_CTRL1)  ? {16'h0000, ctrl1_r} :
      (i_paddr == REG_CTRL2)  ? {16'h0000, alt_r, 15'h0000} :
      (i_paddr == REG_FLAG)   ? {16'h0000, flag_r} :
      (i_paddr == REG_ENABLE) ? {16'h0000, enable_r} :
      (i_paddr == REG_STACK_LIMIT_REG)  ? {16'h0000, stack_limit_reg_r} :
      (i_paddr == REG_SR)     ? {24'h000000, ipl_r, 5'h00} :
      (i_paddr == REG_CORE)   ? {28'h0000000, trap_bit_r, 3'h0} :
      (i_paddr == REG_RESET)  ? {16'h0000, reset_control_reg_r} :
      (i_paddr == REG_STATE)  ? state_word : 32'h00000000;

   logic we_ctrl1;
   logic we_ctrl2;
   logic we_flag;
   logic we_enable;
   logic we_stack_limit_reg;
   logic we_sr;
   logic we_reset;

   assign we_ctrl1  = is_wr(i_paddr, wr_go, REG_CTRL1);
   assign we_ctrl2  = is_wr(i_paddr, wr_go, REG_CTRL2);
   assign we_flag   = is_wr(i_paddr, wr_go, REG_FLAG);
   assign we_enable = is_wr(i_paddr, wr_go, REG_ENABLE);
   assign we_stack_limit_reg  = is_wr(i_paddr, wr_go, REG_STACK_LIMIT_REG);
   assign we_sr     = is_wr(i_paddr, wr_go, REG_SR);
   assign we_reset  = is_wr(i_paddr, wr_go, REG_RESET);

   // ****************************************
   // Trap detection
   // ****************************************
   logic math_hit;
   logic vec_fetch;
   logic bad_fetch;
   logic addr_hit;
   logic stk_hit;
   logic osc_hit;
   logic [3:0] hard_new;

   // Guard bits in use or saturation on absorb the overflow
   assign math_hit = i_evt.div_zero | i_evt.shift_over // see [RULE_08]
      | (ctrl1_r[B_OVF_EN] & i_evt.acc_ovf31 & ~i_evt.guard_used) // see [RULE_09]
      | (ctrl1_r[B_CAT_EN] & i_evt.acc_ovf39 & ~i_evt.sat_en);
   assign vec_fetch = i_evt.fetch_valid // see [RULE_22]
      & (in_range(i_evt.fetch_addr, DEF_LO, DEF_HI)
       | in_range(i_evt.fetch_addr, ALT_LO, ALT_HI));
   // A return to a bad address shows up as this fetch
   assign bad_fetch = i_evt.fetch_valid & (i_evt.fetch_addr >= PROG_END); // see [RULE_12]
   assign addr_hit = i_evt.misaligned | i_evt.unimpl_data // see [RULE_10]
      | i_evt.unimpl_prog | vec_fetch | bad_fetch | i_evt.branch_bad
      | (i_evt.mac_split & (i_evt.x_into_y | i_evt.y_into_x)); // see [RULE_11]
   assign stk_hit = i_evt.sp_load // see [RULE_13]
      & ((i_evt.sp_value > stack_limit_reg_r) | (i_evt.sp_value < SP_FLOOR));
   assign osc_hit = i_evt.osc_fail & ~osc_prev_r; // see [RULE_14]
   assign hard_new = {1'b0, osc_hit, stk_hit, addr_hit};

   logic       trap_any;
   logic [3:0] trap_level;
   logic [3:0] top_hard;
   logic       conflict;

   trap_rank u_rank (
      .i_soft_pend (math_pend_r),
      .i_hard_pend (hard_pend_r),
      .i_hard_srv  (hard_srv_r),
      .i_hard_new  (hard_new),
      .o_any       (trap_any),
      .o_level     (trap_level),
      .o_top_hard  (top_hard),
      .o_conflict  (conflict)
   );

   // ****************************************
   // Interrupt requests
   // ****************************************
   logic [N_IRQ-1:0] irq_req;
   logic [2:0]       irq_level;
   logic [3:0]       irq_idx;

   assign irq_req = flag_r & enable_r; // see [RULE_17]

   irq_pick u_pick (
      .i_req   (irq_req),
      .i_prio  (i_irq_prio),
      .o_level (irq_level),
      .o_index (irq_idx)
   );

   // ****************************************
   // Exception decision
   // ****************************************
   logic        illegal_hit;
   logic        force_rst;
   logic [3:0]  cur_level;
   logic        boundary;
   logic        take_trap;
   logic        take_irq;
   logic [5:0]  vec_num;
   logic [23:0] vec_base;
   logic [3:0]  take_hard;

   assign illegal_hit = i_evt.illegal_op & ~i_evt.flushed; // see [RULE_04]
   assign force_rst = i_evt.wdt_timeout | i_evt.uninit_w // see [RULE_03]
                    | illegal_hit | conflict; // see [RULE_16]
   assign cur_level = {trap_bit_r, ipl_r};
   // A return in the same cycle defers any entry to the next boundary
   assign boundary = i_evt.instr_done & ~i_evt.ret_op & ~force_rst; // see [RULE_07]
   assign take_trap = boundary & trap_any & (trap_level > cur_level); // see [RULE_05]
   // Irq level is at most 7, so level 0111 or any trap blocks it
   assign take_irq = boundary & ~take_trap // see [RULE_24]
                   & ({1'b0, irq_level} > cur_level); // see [RULE_18] see [RULE_06]
   assign vec_num = take_trap ? {2'h0, trap_level - LVL_TRAP0}
                              : IRQ_VEC0 + {2'h0, irq_idx};
   assign vec_base = alt_r ? ALT_LO : DEF_LO; // see [RULE_21]
   assign take_hard = take_trap ? top_hard : 4'h0;

   // ****************************************
   // Next values
   // ****************************************
   logic [15:0] ctrl1_nxt;
   logic [15:0] trap_flags;
   logic [3:0]  hard_ack;
   logic [15:0] reset_control_reg_nxt;
   logic [15:0] reset_control_reg_set;

   assign trap_flags = (16'(i_evt.shift_over) << B_SHIFT)
                     | (16'(i_evt.div_zero) << B_DIV0)
                     | (16'(math_hit) << B_MATH)
                     | (16'(addr_hit) << B_ADDR)
                     | (16'(stk_hit) << B_STK)
                     | (16'(osc_hit) << B_OSC);
   // Hardware set wins over a software clear in the same cycle
   assign ctrl1_nxt = ((we_ctrl1 ? i_pwdata[15:0] : ctrl1_r) & CTRL1_WMASK)
                    | trap_flags;
   // Clearing a hard trap's flag is its acknowledge
   assign hard_ack = {1'b0, ctrl1_nxt[B_OSC], ctrl1_nxt[B_STK], ctrl1_nxt[B_ADDR]};
   assign reset_control_reg_set = (16'(conflict) << B_CONFLICT)
                   | (16'(illegal_hit) << B_ILLEGAL)
                   | (16'(i_evt.wdt_timeout) << B_WDT)
                   | (16'(i_evt.uninit_w) << B_UNINIT);
   assign reset_control_reg_nxt = ((we_reset ? (reset_control_reg_r & ~i_pwdata[15:0]) : reset_control_reg_r)) | reset_control_reg_set;

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ctrl1_r  <= CTRL1_RST;
         alt_r    <= 1'b0;
         flag_r   <= '0;
         enable_r <= '0;
         stack_limit_reg_r  <= STACK_LIMIT_REG_RST;
         reset_control_reg_r   <= 16'h0000;
      end else begin
         ctrl1_r  <= ctrl1_nxt;
         alt_r    <= we_ctrl2 ? i_pwdata[B_ALT] : alt_r; // see [RULE_23]
         flag_r   <= (we_flag ? i_pwdata[N_IRQ-1:0] : flag_r) | i_irq_evt; // see [RULE_17]
         enable_r <= we_enable ? i_pwdata[N_IRQ-1:0] : enable_r;
         stack_limit_reg_r  <= we_stack_limit_reg ? i_pwdata[15:0] : stack_limit_reg_r;
         reset_control_reg_r   <= reset_control_reg_nxt;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         math_pend_r <= 1'b0;
         hard_pend_r <= 4'h0;
         hard_srv_r  <= 4'h0;
         ipl_r       <= 3'h0;
         trap_bit_r  <= 1'b0;
      end else if (force_rst) begin
         math_pend_r <= 1'b0;
         hard_pend_r <= 4'h0;
         hard_srv_r  <= 4'h0;
         ipl_r       <= 3'h0;
         trap_bit_r  <= 1'b0;
      end else begin
         math_pend_r <= math_hit | (math_pend_r & ~(take_trap & ~(|top_hard)));
         hard_pend_r <= hard_new | (hard_pend_r & ~take_hard);
         hard_srv_r  <= (hard_srv_r | take_hard) & hard_ack; // see [RULE_16]
         if (take_trap | take_irq) begin
            ipl_r      <= take_trap ? trap_level[2:0] : irq_level; // see [RULE_19]
            trap_bit_r <= take_trap; // see [RULE_05] see [RULE_20]
         end else if (i_evt.ret_op) begin
            ipl_r      <= i_pop.status_low_byte[SR_IPL_LSB +: 3]; // see [RULE_19]
            trap_bit_r <= i_pop.trap_bit;
         end else if (we_sr) begin
            ipl_r      <= i_pwdata[SR_IPL_LSB +: 3];
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         osc_prev_r   <= 1'b0;
         core_reset_r <= 1'b0;
         pc_load_r    <= 1'b1;
         pc_value_r   <= RESET_VEC;
         take_r       <= 1'b0;
         vector_r     <= 24'h000000;
         frame_r      <= '0;
      end else begin
         osc_prev_r   <= i_evt.osc_fail;
         core_reset_r <= force_rst; // see [RULE_03]
         // The core's jump at word zero then reaches the start code
         pc_load_r    <= force_rst; // see [RULE_01] see [RULE_02]
         pc_value_r   <= RESET_VEC;
         take_r       <= take_trap | take_irq;
         if (take_trap | take_irq) begin
            vector_r <= vec_base + {17'h00000, vec_num, 1'b0}; // see [RULE_15]
            frame_r  <= '{pc: i_evt.pc, status_low_byte: {ipl_r, 5'h00}, trap_bit: trap_bit_r};
         end
      end
   end

   // Reads are latched in the setup cycle, so access ends in one cycle
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h00000000;
      end else begin
         pready_r  <= setup;
         pslverr_r <= setup & ~hit;
         prdata_r  <= setup ? rd_mux : prdata_r;
      end
   end

   assign o_prdata     = prdata_r;
   assign o_pready     = pready_r;
   assign o_pslverr    = pslverr_r;
   assign o_core_reset = core_reset_r;
   assign o_pc_load    = pc_load_r;
   assign o_pc_value   = pc_value_r;
   assign o_take       = take_r;
   assign o_vector     = vector_r;
   assign o_frame      = frame_r;
   assign o_level      = {trap_bit_r, ipl_r};

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   sequence s_trap_entry;
      take_trap ##1 o_take;
   endsequence

   sequence s_irq_entry;
      take_irq ##1 o_take;
   endsequence

   reset_restart_a : assert property ( // see [RULE_01]
      force_rst |=> o_core_reset && o_pc_load && o_pc_value == 24'h000000
                    ##1 !o_pc_load)
      else $error("forced reset did not restart fetch at zero");

   flush_ignore_a : assert property ( // see [RULE_04]
      i_evt.illegal_op && i_evt.flushed && !i_evt.wdt_timeout
      && !i_evt.uninit_w && !conflict |=> !o_core_reset)
      else $error("flushed opcode caused a reset");

   trap_bit_a : assert property ( // see [RULE_05]
      s_trap_entry |-> o_level[3] && o_vector < 24'h000114)
      else $error("trap entry without trap bit");

   irq_clear_a : assert property ( // see [RULE_20]
      s_irq_entry |-> !o_level[3] && o_frame.trap_bit == 1'b0)
      else $error("interrupt entry with trap bit set");

   level_block_a : assert property ( // see [RULE_06]
      cur_level == 4'h7 |-> !take_irq)
      else $error("interrupt taken at level seven");

   strict_prio_a : assert property ( // see [RULE_18]
      o_take && !o_level[3] |-> o_level > $past(o_level))
      else $error("interrupt not above previous level");

   stack_floor_a : assert property ( // see [RULE_13]
      i_evt.sp_load && i_evt.sp_value < 16'h0800 |=> ctrl1_r[B_STK] && (hard_pend_r[1] || o_core_reset))
      else $error("stack underflow not flagged");

   conflict_rst_a : assert property ( // see [RULE_16]
      conflict |=> o_core_reset && reset_control_reg_r[15] && hard_pend_r == 4'h0)
      else $error("hard trap conflict not reset");

   alt_table_a : assert property ( // see [RULE_21]
      (take_trap || take_irq) && alt_r |=> o_take && o_vector >= 24'h000104)
      else $error("alternate table not used");

   flag_sample_a : assert property ( // see [RULE_17]
      i_irq_evt[0] |=> flag_r[0])
      else $error("event flag not sampled");

   trap_first_a : assert property ( // see [RULE_24]
      take_trap |-> !take_irq ##1 o_take && o_level >= 4'h8)
      else $error("interrupt beat a trap");
endmodule

// file: verif/pipe_model.sv
// Purpose: core pipeline stand-in facing the sequencer
// Assumes: single-cycle instructions
// Notes:   bench requests events, the model adds the boundary strobe
`timescale 1ns/1ns
module pipe_model
   import trap_seq_pkg::*;
(
   // Requests from bench
   input  wire core_evt_t i_req,
   // To sequencer
   output core_evt_t      o_evt
);
   // Every cycle ends an instruction, so a trap is entered only after it completes
   always_comb begin
      o_evt            = i_req;
      o_evt.instr_done = 1'b1;
   end
endmodule

// file: verif/tb.sv
// Purpose: self-checking bench of the trap and interrupt sequencer
// Assumes: APB slave answers on its own pace, core ends every cycle
// Notes:   each group of scenarios starts from a fresh reset
`timescale 1ns/1ns
module tb
   import trap_seq_pkg::*;
;
   logic                  clk = 1'b0;
   logic                  resetn = 1'b0;
   logic                  psel = 1'b0;
   logic                  penable = 1'b0;
   logic                  pwrite = 1'b0;
   logic [7:0]            paddr = 8'h00;
   logic [31:0]           pwdata = 32'h0;
   logic [31:0]           prdata, r;
   logic                  pready, pslverr, core_reset, pc_load, take, er, hit;
   logic [23:0]           pc_value, vector;
   logic [3:0]            level;
   frame_t                frame;
   frame_t                pop = '0;
   core_evt_t             ev = '0;
   core_evt_t             evt, e;
   logic [N_IRQ-1:0]      irq_evt = '0;
   logic [N_IRQ-1:0][2:0] irq_prio = {16{3'h3}};
   int                    bad_count = 0;
   int                    checked = 0;
   always #5 clk = ~clk;
   pipe_model model (.i_req(ev), .o_evt(evt));
   trap_and_interrupt_sequencer dut (.i_clk(clk), .i_resetn(resetn), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_evt(evt), .i_pop(pop), .o_core_reset(core_reset), .o_pc_load(pc_load),
      .o_pc_value(pc_value), .o_take(take), .o_vector(vector), .o_frame(frame), .o_level(level),
      .i_irq_evt(irq_evt), .i_irq_prio(irq_prio));
   // ****************************************
   // Bus, event and reset helpers
   // ****************************************
   task chk(input string n, input logic [31:0] x, input logic [31:0] g);
      checked++;
      if (g !== x) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, x, g);
      end
   endtask
   // Data and error are taken at the edge that sees pready high; the watchdog ends a hung wait
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // One-cycle outputs are polled at every edge so none is missed
   task wait_for(input logic rs);
      hit = 1'b0;
      for (int n = 0; n < 8 && hit !== 1'b1; n++) begin
         @(posedge clk);
         hit = rs ? core_reset : take;
      end
   endtask
   task fire(input logic rs);
      @(posedge clk);
      ev <= e;
      @(posedge clk);
      ev <= '0;
      wait_for(rs);
   endtask
   task rst();
      @(posedge clk);
      resetn <= 1'b0;
      ev <= '0;
      irq_evt <= '0;
      repeat (5) @(posedge clk);
      chk("pc_load", 32'h1, {31'h0, pc_load});
      chk("pc_value", 32'h0, {8'h0, pc_value});
      resetn <= 1'b1;
   endtask
   task summarize();
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      #100000;
      bad_count++;
      summarize();
   end
   initial begin
      rst();
      apb(1'b0, 8'hFC, 32'h0);
      chk("pslverr", 32'h1, {31'h0, er});
      e = '0;
      e.fetch_valid = 1'b1;
      e.fetch_addr = 24'h000010;
      fire(1'b0);
      chk("addr_vec", 32'h0C, {8'h0, vector});
      chk("addr_lvl", 32'hC, {28'h0, level});
      e = '0;
      e.osc_fail = 1'b1;
      fire(1'b0);
      chk("osc_vec", 32'h10, {8'h0, vector});
      chk("osc_srl", 32'h80, {24'h0, frame.status_low_byte});
      e = '0;
      e.sp_load = 1'b1;
      e.sp_value = 16'h0700;
      fire(1'b1);
      chk("conflict", 32'h1, {31'h0, hit});
      apb(1'b0, REG_RESET, 32'h0);
      chk("conflict_flag", 32'h1, {31'h0, r[B_CONFLICT]});
      rst();
      e = '0;
      e.illegal_op = 1'b1;
      e.flushed = 1'b1;
      fire(1'b1);
      chk("flushed", 32'h0, {31'h0, hit});
      for (int k = 0; k < 3; k++) begin
         rst();
         e = '0;
         e.illegal_op = (k == 0);
         e.uninit_w = (k == 1);
         e.wdt_timeout = (k == 2);
         fire(1'b1);
         chk("reload", 32'h1, {31'h0, pc_load});
         apb(1'b0, REG_RESET, 32'h0);
         chk("cause", 32'h1, {31'h0, r[k == 0 ? B_ILLEGAL : k == 1 ? B_UNINIT : B_WDT]});
      end
      rst();
      apb(1'b1, REG_SR, 32'hE0);
      apb(1'b1, REG_ENABLE, 32'h1);
      irq_evt[0] <= 1'b1;
      wait_for(1'b0);
      chk("ipl7_block", 32'h0, {31'h0, hit});
      e = '0;
      e.div_zero = 1'b1;
      fire(1'b0);
      chk("math_vec", 32'h0A, {8'h0, vector});
      chk("math_lvl", 32'hB, {28'h0, level});
      rst();
      apb(1'b1, REG_ENABLE, 32'h1);
      apb(1'b1, REG_SR, 32'h60);
      irq_evt[0] <= 1'b1;
      wait_for(1'b0);
      chk("equal_block", 32'h0, {31'h0, hit});
      apb(1'b1, REG_SR, 32'h40);
      wait_for(1'b0);
      chk("irq_vec", 32'h14, {8'h0, vector});
      chk("irq_lvl", 32'h3, {28'h0, level});
      chk("irq_srl", 32'h40, {24'h0, frame.status_low_byte});
      // Return to level seven: the still-set flag must not re-enter
      e = '0;
      e.ret_op = 1'b1;
      pop.status_low_byte <= 8'hE0;
      fire(1'b0);
      chk("ret_lvl", 32'h7, {28'h0, level});
      chk("ret_block", 32'h0, {31'h0, hit});
      rst();
      apb(1'b1, REG_CTRL2, 32'h8000);
      apb(1'b1, REG_ENABLE, 32'h1);
      irq_evt[0] <= 1'b1;
      wait_for(1'b0);
      chk("alt_vec", 32'h114, {8'h0, vector});
      summarize();
   end
endmodule
